// file: core/eitr_cfg.svh
`ifndef EITR_CFG_SVH
`define EITR_CFG_SVH
// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define EITR_ADDR_MODE      8'hD8
`define EITR_ADDR_COUNT     8'hD9
`define EITR_ADDR_IRQ_STAT  8'hDA
`define EITR_ADDR_IRQ_MASK  8'hDB
// ------------------------------------------------------------
// mode field positions and reset values
// ------------------------------------------------------------
`define EITR_BIT_RUN        7
`define EITR_BIT_RATE_HI    6
`define EITR_BIT_RATE_LO    4
`define EITR_BIT_SPD1_X8    3
`define EITR_BIT_SPD0_X8    2
`define EITR_BIT_GREEN_WAKE 1
`define EITR_BIT_RTC        0
`define EITR_MODE_RESET     8'h00
`define EITR_COUNT_RESET    8'h00
`define EITR_COUNT_WRAP     8'hFF
`define EITR_BIT_IRQ        0
// ------------------------------------------------------------
// timing: rtc half second from a 32.768 kHz crystal
// ------------------------------------------------------------
`define EITR_RTC_HZ         32768
`define EITR_RTC_PERIOD_MS  500
`define EITR_RTC_TICKS      ((`EITR_RTC_HZ * `EITR_RTC_PERIOD_MS) / 1000)
`endif

// file: core/eitr_pkg.sv
package eitr_pkg;
  typedef struct packed {
    logic       run;
    logic [2:0] rate;
    logic       spd1_x8;
    logic       spd0_x8;
    logic       green_wake;
    logic       rtc;
  } eitr_mode_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } eitr_bus_t;
endpackage

// file: core/eitr_sync.sv
`timescale 1ns/1ps
`default_nettype none
module eitr_sync
(
  input  wire logic mclk_i,
  input  wire logic reset_i,
  input  wire logic d_i,
  output var  logic q_o
);
  logic stage1;
  // ----------------------------------------------------------
  // two stage synchroniser; stage1 feeds only q_o
  // ----------------------------------------------------------
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      stage1 <= 1'b0;
      q_o    <= 1'b0;
    end
    else
    begin
      stage1 <= d_i;
      q_o    <= stage1;
    end
  end
endmodule
`default_nettype wire

// file: core/eitr_timer.sv
// Local design decision: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "eitr_cfg.svh"
module eitr_timer
(
  input  wire logic             mclk_i,
  input  wire logic             reset_i,
  input  wire eitr_pkg::eitr_bus_t bus_i,
  output var  logic [7:0]       rdata_o,
  input  wire logic             instr_tick_i,
  input  wire logic             rtc_xtal_i,
  input  wire logic             green_mode_i,
  output var  logic             irq_o,
  output var  logic             green_wake_req_o,
  output var  logic             first_counter_speed_x8_o,
  output var  logic             second_counter_speed_x8_o,
  output var  logic             first_counter_green_wake_o
);
  import eitr_pkg::*;

  eitr_mode_t mode_control;
  logic [7:0] count_value;
  logic       timer_irq_flag;
  logic       timer_irq_enable;
  logic [7:0] prescale;
  logic [13:0] rtc_ticks;
  logic       xtal_sync;
  logic       xtal_prev;
  logic       xtal_rise;
  logic       count_step;
  logic       rate_hit;
  logic       rtc_hit;
  logic       wrap;
  logic       wr_mode;
  logic       wr_count;
  logic       wr_stat;
  logic       wr_mask;
  logic [7:0] next_rdata;

  // ----------------------------------------------------------
  // crystal input crossing
  // ----------------------------------------------------------
  eitr_sync u_xtal_sync
  (
    .mclk_i  (mclk_i),
    .reset_i (reset_i),
    .d_i     (rtc_xtal_i),
    .q_o     (xtal_sync)
  );

  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
      xtal_prev <= 1'b0;
    else
      xtal_prev <= xtal_sync;
  end

  assign xtal_rise = xtal_sync & ~xtal_prev;

  // ----------------------------------------------------------
  // decode
  // ----------------------------------------------------------
  assign wr_mode  = bus_i.wr && (bus_i.addr == `EITR_ADDR_MODE);
  assign wr_count = bus_i.wr && (bus_i.addr == `EITR_ADDR_COUNT);
  assign wr_stat  = bus_i.wr && (bus_i.addr == `EITR_ADDR_IRQ_STAT);
  assign wr_mask  = bus_i.wr && (bus_i.addr == `EITR_ADDR_IRQ_MASK);

  // ----------------------------------------------------------
  // mode register
  // ----------------------------------------------------------
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
      mode_control <= `EITR_MODE_RESET;
    else if (wr_mode)
      mode_control <= bus_i.wdata;
  end

  assign first_counter_speed_x8_o   = mode_control.spd0_x8;
  assign second_counter_speed_x8_o  = mode_control.spd1_x8;
  assign first_counter_green_wake_o = mode_control.green_wake;

  // ----------------------------------------------------------
  // prescaler: held at zero unless running outside rtc mode, tap chosen by rate
  // ----------------------------------------------------------
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
      prescale <= 8'h00;
    else if (!mode_control.run || mode_control.rtc)
      prescale <= 8'h00;
    else if (instr_tick_i)
      prescale <= prescale + 8'h01;
  end

  // code 000 divides by 256, each step halves the divisor
  always_comb
  begin
    rate_hit = 1'b0;
    if (instr_tick_i)
    begin
      case (mode_control.rate)
        3'h0:    rate_hit = (prescale == 8'hFF);
        3'h1:    rate_hit = (prescale[6:0] == 7'h7F);
        3'h2:    rate_hit = (prescale[5:0] == 6'h3F);
        3'h3:    rate_hit = (prescale[4:0] == 5'h1F);
        3'h4:    rate_hit = (prescale[3:0] == 4'hF);
        3'h5:    rate_hit = (prescale[2:0] == 3'h7);
        3'h6:    rate_hit = (prescale[1:0] == 2'h3);
        3'h7:    rate_hit = prescale[0];
        default: rate_hit = 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------
  // rtc half second divider
  // ----------------------------------------------------------
  // rate and loaded count play no part here, so the period is fixed
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
      rtc_ticks <= 14'h0000;
    else if (!mode_control.run || !mode_control.rtc)
      rtc_ticks <= 14'h0000;
    else if (xtal_rise)
    begin
      if (rtc_ticks == 14'(`EITR_RTC_TICKS - 1))
        rtc_ticks <= 14'h0000;
      else
        rtc_ticks <= rtc_ticks + 14'h0001;
    end
  end

  assign rtc_hit = xtal_rise && (rtc_ticks == 14'(`EITR_RTC_TICKS - 1));

  // ----------------------------------------------------------
  // counter
  // ----------------------------------------------------------
  assign count_step = mode_control.run && (mode_control.rtc ? rtc_hit : rate_hit);
  // in rtc mode the wrap is the divider end, not the counter value
  assign wrap = count_step && (mode_control.rtc || count_value == `EITR_COUNT_WRAP);

  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
      count_value <= `EITR_COUNT_RESET;
    else if (wr_count)
      count_value <= bus_i.wdata;
    else if (count_step)
      count_value <= count_value + 8'h01;
  end

  // ----------------------------------------------------------
  // interrupt status and mask
  // ----------------------------------------------------------
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
      timer_irq_flag <= 1'b0;
    else if (wrap)
      timer_irq_flag <= 1'b1;
    else if (wr_stat && bus_i.wdata[`EITR_BIT_IRQ])
      timer_irq_flag <= 1'b0;
  end

  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
      timer_irq_enable <= 1'b0;
    else if (wr_mask)
      timer_irq_enable <= bus_i.wdata[`EITR_BIT_IRQ];
  end

  assign irq_o = timer_irq_flag & timer_irq_enable;

  // one cycle pulse on a wrap seen while green
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
      green_wake_req_o <= 1'b0;
    else
      green_wake_req_o <= wrap && mode_control.run && green_mode_i;
  end

  // ----------------------------------------------------------
  // read port
  // ----------------------------------------------------------
  always_comb
  begin
    next_rdata = 8'h00;
    case (bus_i.addr)
      `EITR_ADDR_MODE:     next_rdata = mode_control;
      `EITR_ADDR_COUNT:    next_rdata = count_value;
      `EITR_ADDR_IRQ_STAT: next_rdata = {7'h00, timer_irq_flag};
      `EITR_ADDR_IRQ_MASK: next_rdata = {7'h00, timer_irq_enable};
      default:             next_rdata = 8'h00;
    endcase
  end

  // data stands only in the cycle after the read strobe
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
      rdata_o <= 8'h00;
    else if (bus_i.rd)
      rdata_o <= next_rdata;
    else
      rdata_o <= 8'h00;
  end
endmodule
`default_nettype wire

// file: testbench/eitr_timer_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "eitr_cfg.svh"
module eitr_timer_properties
(
  input wire logic                mclk_i,
  input wire logic                reset_i,
  input wire eitr_pkg::eitr_bus_t bus_i,
  input wire logic [7:0]          rdata_o,
  input wire logic                green_mode_i,
  input wire logic                irq_o,
  input wire logic                green_wake_req_o,
  input wire logic                first_counter_speed_x8_o,
  input wire logic                second_counter_speed_x8_o,
  input wire logic                first_counter_green_wake_o
);
  import eitr_pkg::*;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  wire logic mode_wr = bus_i.wr && bus_i.addr == `EITR_ADDR_MODE;
  // status and mask writes are the only legal ways for irq_o to drop
  wire logic irq_wr = bus_i.wr && (bus_i.addr == `EITR_ADDR_IRQ_STAT || bus_i.addr == `EITR_ADDR_IRQ_MASK);
  a_speed_follow: assert property (mode_wr |=>
    first_counter_speed_x8_o == $past(bus_i.wdata[2]) && second_counter_speed_x8_o == $past(bus_i.wdata[3]))
    else $error("speed outputs not updated");
  a_wake_follow: assert property (mode_wr |=> first_counter_green_wake_o == $past(bus_i.wdata[1]))
    else $error("green wake enable not updated");
  a_mode_hold: assert property (!mode_wr |=>
    $stable({first_counter_speed_x8_o, second_counter_speed_x8_o, first_counter_green_wake_o}))
    else $error("mode outputs moved without a write");
  a_wake_green: assert property (green_wake_req_o |-> $past(green_mode_i))
    else $error("wake request outside green mode");
  a_wake_pulse: assert property (green_wake_req_o |=> !green_wake_req_o)
    else $error("wake request longer than one cycle");
  a_irq_sticky: assert property (irq_o && !irq_wr |=> irq_o)
    else $error("interrupt dropped by itself");
  a_irq_clear: assert property ($fell(irq_o) |-> $past(irq_wr))
    else $error("interrupt fell without a write");
  a_rdata_idle: assert property (!$past(bus_i.rd) |-> rdata_o == 8'h00)
    else $error("read data outside read slot");
endmodule
`default_nettype wire

// file: testbench/eitr_timer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module eitr_timer_tb;
  import eitr_pkg::*;
  logic       mclk_i = 0, reset_i = 1, instr_tick_i = 0, rtc_xtal_i = 0, green_mode_i = 0, xt_en = 0;
  eitr_bus_t  bus_i = '0;
  logic [7:0] rdata_o, m_mode, m_cnt, exp_rd;
  logic       irq_o, green_wake_req_o, fs, ss, fg, m_flag, m_mask, m_wake, pend, wrap;
  int         err_total = 0, total_checks = 0, psc, xc = 0, rtk;
  logic [2:0] xs;
  always #5 mclk_i = ~mclk_i;
  eitr_timer u_eitr_timer (.mclk_i(mclk_i), .reset_i(reset_i), .bus_i(bus_i), .rdata_o(rdata_o),
    .instr_tick_i(instr_tick_i), .rtc_xtal_i(rtc_xtal_i), .green_mode_i(green_mode_i), .irq_o(irq_o),
    .green_wake_req_o(green_wake_req_o), .first_counter_speed_x8_o(fs), .second_counter_speed_x8_o(ss),
    .first_counter_green_wake_o(fg));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // one idle cycle after each access keeps a strobe from being driven twice in a time step
  task automatic acc(input logic [7:0] a, input logic [7:0] d, input logic w);
    @(posedge mclk_i);
    bus_i <= {a, d, w, !w};
    @(posedge mclk_i);
    bus_i <= {a, d, 2'b00};
  endtask
  // ------------------------------------------------------------
  // stimulus and model
  // ------------------------------------------------------------
  always @(posedge mclk_i)
  begin
    instr_tick_i <= 1'($urandom);
    green_mode_i <= 1'($urandom);
    xc <= xc + 1;
    // two cycles per crystal half period keeps one rtc interval near 65k cycles
    if (xt_en && xc % 2 == 1)
      rtc_xtal_i <= ~rtc_xtal_i;
  end
  always @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      {m_mode, m_cnt, m_flag, m_mask, m_wake, pend, psc} = '0;
      rtk = 0;
      xs = 3'h0;
    end
    else
    begin
      pend = bus_i.rd;
      case (bus_i.addr)
        8'hD8: exp_rd = m_mode;
        8'hD9: exp_rd = m_cnt;
        8'hDA: exp_rd = {7'h00, m_flag};
        8'hDB: exp_rd = {7'h00, m_mask};
        default: exp_rd = 8'h00;
      endcase
      wrap = 0;
      // crystal passes two flops and an edge detector before it counts
      if (!m_mode[7] || !m_mode[0])
        rtk = 0;
      else if (xs[1] && !xs[2])
      begin
        if (rtk == 16383)
        begin
          wrap = 1;
          m_cnt = m_cnt + 8'h01;
          rtk = 0;
        end
        else
          rtk++;
      end
      xs = {xs[1:0], rtc_xtal_i};
      if (!m_mode[7] || m_mode[0])
        psc = 0;
      else if (instr_tick_i)
      begin
        if (psc % (256 >> m_mode[6:4]) == (256 >> m_mode[6:4]) - 1)
        begin
          wrap = m_cnt == 8'hFF;
          m_cnt = m_cnt + 8'h01;
        end
        psc++;
      end
      m_wake = wrap && green_mode_i;
      if (bus_i.wr && bus_i.addr == 8'hD8) m_mode = bus_i.wdata;
      if (bus_i.wr && bus_i.addr == 8'hD9) m_cnt = bus_i.wdata;
      if (bus_i.wr && bus_i.addr == 8'hDA && bus_i.wdata[0]) m_flag = 0;
      if (bus_i.wr && bus_i.addr == 8'hDB) m_mask = bus_i.wdata[0];
      if (wrap) m_flag = 1;
    end
  end
  always @(negedge mclk_i)
  begin
    if (!reset_i)
    begin
      chk(rdata_o, pend ? exp_rd : 8'h00);
      chk({7'h00, irq_o}, {7'h00, m_flag & m_mask});
      chk({7'h00, green_wake_req_o}, {7'h00, m_wake});
      chk({5'h00, ss, fs, fg}, {5'h00, m_mode[3:1]});
    end
  end
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial
  begin
    void'($urandom(52306));
    repeat (6) @(posedge mclk_i);
    reset_i <= 0;
    for (int i = 0; i < 5; i++)
      acc((i == 4) ? 8'hD0 : 8'(8'hD8 + i), 8'h00, 0);
    for (int c = 0; c < 8; c++)
    begin
      acc(8'hD8, 8'h00, 1);
      acc(8'hDA, 8'h01, 1);
      acc(8'hD9, 8'hFE, 1);
      acc(8'hDB, {7'h00, ~c[0]}, 1);
      acc(8'hD8, {1'b1, c[2:0], 3'($urandom), 1'b0}, 1);
      repeat ((256 >> c) * 8) @(posedge mclk_i);
      acc(8'hD9, 8'h00, 0);
      acc(8'hD8, 8'h00, 1);
      repeat (20) @(posedge mclk_i);
      acc(8'hD9, 8'h00, 0);
    end
    acc(8'hDA, 8'h01, 1);
    acc(8'hDB, 8'h01, 1);
    acc(8'hD9, 8'h42, 1);
    acc(8'hD8, 8'hF1, 1);
    xt_en <= 1;
    repeat (65600) @(posedge mclk_i);
    acc(8'hD9, 8'h00, 0);
    acc(8'hDA, 8'h00, 0);
    acc(8'hD8, 8'h00, 1);
    summarize();
  end
  initial
  begin
    #900us;
    err_total++;
    summarize();
  end
endmodule
bind eitr_timer eitr_timer_properties u_eitr_timer_properties (.mclk_i(mclk_i), .reset_i(reset_i),
  .bus_i(bus_i), .rdata_o(rdata_o), .green_mode_i(green_mode_i), .irq_o(irq_o),
  .green_wake_req_o(green_wake_req_o), .first_counter_speed_x8_o(first_counter_speed_x8_o),
  .second_counter_speed_x8_o(second_counter_speed_x8_o), .first_counter_green_wake_o(first_counter_green_wake_o));
`default_nettype wire
